// *** include/ctp_defines.svh ***
// register offsets, field positions, reset values and codes of the cascaded timer
`ifndef CTP_DEFINES_SVH
`define CTP_DEFINES_SVH
// register word indices (byte address = 4 * index)
`define CTP_IDX_LOWER_CTL   3'h0
`define CTP_IDX_UPPER_CTL   3'h1
`define CTP_IDX_PER_LOW     3'h2
`define CTP_IDX_PER_HIGH    3'h3
`define CTP_IDX_DUTY_LOW    3'h4
`define CTP_IDX_DUTY_HIGH   3'h5
`define CTP_IDX_INT_EN      3'h6
`define CTP_IDX_COUNT       3'h7
// upper_timer_control fields
`define CTP_UC_INIT_BIT     7
`define CTP_UC_RUN_BIT      3
`define CTP_UC_MODE_HI      2
// lower_timer_control fields
`define CTP_LC_SRC_HI       6
`define CTP_LC_SRC_LO       4
`define CTP_LC_MODE_HI      2
// upper_int_enable_reg fields
`define CTP_IE_PERIOD_BIT   4
`define CTP_IE_MASTER_BIT   0
// mode codes
`define CTP_LMODE_CASCADE   3'h3
`define CTP_MODE_TIMER16    3'h4
`define CTP_MODE_PWM16      3'h6
`define CTP_MODE_PPG16      3'h7
// source clock codes
`define CTP_SRC_SLOWEST     3'h0
`define CTP_SRC_LF          3'h4
`define CTP_SRC_EXT         3'h7
// tick input bit positions
`define CTP_TK_HF_D2048     0
`define CTP_TK_LF_D8        1
`define CTP_TK_HF_D128      2
`define CTP_TK_HF_D32       3
`define CTP_TK_HF_D8        4
`define CTP_TK_LF           5
`define CTP_TK_HF_D2        6
`define CTP_TK_HF           7
// reset values, counter maximum and count step
`define CTP_RST_BYTE        8'h00
`define CTP_RST_WORD        16'h0000
`define CTP_CNT_MAX         16'hFFFF
`define CTP_WR_BYTES        16'h0001
`endif

// *** include/ctp_pkg.sv ***
// types of the cascaded timer
package ctp_pkg;
   typedef enum logic [2:0] {
      CTP_BUS_IDLE  = 3'b001,
      CTP_BUS_WRITE = 3'b010,
      CTP_BUS_READ  = 3'b100
   } ctp_bus_t;

   typedef struct packed {
      ctp_bus_t    bus;
      logic [2:0]  addr;
      logic        mapped;
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
      logic [7:0]  lctl;
      logic [7:0]  uctl;
      logic [15:0] per;
      logic [15:0] duty_pend;
      logic [15:0] duty_act;
      logic [7:0]  ie;
      logic [15:0] cnt;
      logic        ff;
      logic        pwm_pin;
      logic        ppg_pin;
      logic        irq;
      logic [1:0]  hist;
      logic        ext_lvl;
   } ctp_state_t;
endpackage

// *** src/ctp_timer.sv ***
// cascaded 16-bit timer with interval, pwm and pulse-generator modes behind ahb-lite
// Notes on behaviour
// - two byte timers form one 16-bit up-counter on the chosen source tick
// - timer mode: period match raises interrupt, clears counter, counting continues
// - timer mode period compare has no shadow, takes effect at once
// - timer mode offers four slowest sources, first one low-freq when option or slow
// - pwm: duty match toggles flop; overflow toggles, clears, raises interrupt
// - pwm pin always drives the inverse of the output flop
// - flop loads its initial level from control bit, reset clears it
// - pwm duty written while running waits in shadow until period interrupt
// - pwm duty read returns the active value until the transfer
// - stopped flop holds; initial bit loads only on a write while stopped
// - pwm mode adds low-freq, half high-freq and high-freq sources
// - pulse-gen: duty match toggles, period match toggles, clears, interrupts
// - pulse-gen duty and period compares are unbuffered
// - external count input needs each level held two cycles
// - interrupt only when period enable bit 4 and master enable are set
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`include "ctp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ctp_timer (
   // clock and reset
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   // ahb-lite slave
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic [31:0]               hrdata,
   output logic                      hresp,
   // prescaler ticks and run conditions
   input  wire logic [7:0]           source_ticks,
   input  wire logic                 divider_clock_option,
   input  wire logic                 slow_run_modes,
   input  wire logic                 count_input_pin,
   // outputs
   output logic                      pwm_output_pin,
   output logic                      pulse_gen_output_pin,
   output logic                      period_interrupt
);
   import ctp_pkg::*;

   ctp_state_t st;
   ctp_state_t next_st;
   logic       tick;
   logic       step;
   logic       evt;
   logic       ext_tick;
   logic [15:0] cnt_inc;
   logic [2:0] mode;
   logic       run;
   logic       ctl_wr;

   // pick the counting tick for the selected source and mode
   function automatic logic pick_tick(input logic [2:0] src, input logic [2:0] md,
                                      input logic [7:0] tk, input logic slow,
                                      input logic dvk, input logic ext);
      logic t;
      t = 1'b0;
      case (src)
         3'h0: t = (dvk || slow) ? tk[`CTP_TK_LF_D8] : tk[`CTP_TK_HF_D2048];
         3'h1: t = !slow && tk[`CTP_TK_HF_D128];
         3'h2: t = !slow && tk[`CTP_TK_HF_D32];
         3'h3: t = !slow && tk[`CTP_TK_HF_D8];
         3'h4: t = (md == `CTP_MODE_PWM16) && tk[`CTP_TK_LF];
         3'h5: t = (md == `CTP_MODE_PWM16) && !slow && tk[`CTP_TK_HF_D2];
         3'h6: t = (md == `CTP_MODE_PWM16) && !slow && tk[`CTP_TK_HF];
         3'h7: t = ext;
         default: t = 1'b0;
      endcase
      return t;
   endfunction

   // a field is a whole-byte register read back in the low lane
   function automatic logic [31:0] byte_word(input logic [7:0] b);
      return {24'h000000, b};
   endfunction

   assign mode = st.uctl[`CTP_UC_MODE_HI:0];
   assign run  = st.uctl[`CTP_UC_RUN_BIT];
   assign ctl_wr = (st.bus == CTP_BUS_WRITE) && st.mapped && (st.addr == `CTP_IDX_UPPER_CTL);
   // external pulse counts only after both levels were seen for two cycles
   assign ext_tick = st.ext_lvl && (st.hist == 2'b00);
   assign tick = pick_tick(st.lctl[`CTP_LC_SRC_HI:`CTP_LC_SRC_LO], mode, source_ticks,
                           slow_run_modes, divider_clock_option, ext_tick);
   // counting only in the three cascaded modes with the lower byte joined
   assign step = run && tick && (st.lctl[`CTP_LC_MODE_HI:0] == `CTP_LMODE_CASCADE)
                 && (mode == `CTP_MODE_TIMER16 || mode == `CTP_MODE_PWM16
                     || mode == `CTP_MODE_PPG16);
   assign cnt_inc = st.cnt + `CTP_WR_BYTES;

   // one combinational pass builds the next state
   always_comb begin
      next_st = st;
      evt     = 1'b0;
      // bus: writes are zero-wait, reads insert one wait so hrdata comes from a flop
      next_st.bus = CTP_BUS_IDLE;
      if (st.bus == CTP_BUS_READ) begin
         next_st.hreadyout = 1'b1;
         next_st.hrdata    = 32'h00000000;
         if (st.mapped) begin
            case (st.addr)
               `CTP_IDX_LOWER_CTL: next_st.hrdata = byte_word(st.lctl);
               `CTP_IDX_UPPER_CTL: next_st.hrdata = byte_word(st.uctl);
               `CTP_IDX_PER_LOW:   next_st.hrdata = byte_word(st.per[7:0]);
               `CTP_IDX_PER_HIGH:  next_st.hrdata = byte_word(st.per[15:8]);
               `CTP_IDX_DUTY_LOW:  next_st.hrdata = byte_word(st.duty_act[7:0]);
               `CTP_IDX_DUTY_HIGH: next_st.hrdata = byte_word(st.duty_act[15:8]);
               `CTP_IDX_INT_EN:    next_st.hrdata = byte_word(st.ie);
               `CTP_IDX_COUNT:     next_st.hrdata = {16'h0000, st.cnt};
               default:            next_st.hrdata = 32'h00000000;
            endcase
         end
      end
      if (hsel && htrans[1] && hready) begin
         next_st.addr   = haddr[4:2];
         next_st.mapped = (haddr[31:5] == 27'h0000000) && (haddr[1:0] == 2'b00);
         if (hwrite) begin
            next_st.bus = CTP_BUS_WRITE;
         end else begin
            next_st.bus       = CTP_BUS_READ;
            next_st.hreadyout = 1'b0;
         end
      end
      next_st.hresp = 1'b0;

      // external input level filter
      next_st.hist = {st.hist[0], count_input_pin};
      if (st.hist == 2'b11) begin
         next_st.ext_lvl = 1'b1;
      end else if (st.hist == 2'b00) begin
         next_st.ext_lvl = 1'b0;
      end

      // counting and compare; a halted counter keeps value and flop
      if (step) begin
         next_st.cnt = cnt_inc;
         case (mode)
            `CTP_MODE_TIMER16: begin
               if (cnt_inc == st.per) begin
                  next_st.cnt = `CTP_RST_WORD;
                  evt = 1'b1;
               end
            end
            `CTP_MODE_PWM16: begin
               if (st.cnt == `CTP_CNT_MAX) begin
                  next_st.ff  = !st.ff;
                  next_st.cnt = `CTP_RST_WORD;
                  evt = 1'b1;
               end else if (cnt_inc == st.duty_act) begin
                  next_st.ff = !st.ff;
               end
            end
            `CTP_MODE_PPG16: begin
               if (cnt_inc == st.per) begin
                  next_st.ff  = !st.ff;
                  next_st.cnt = `CTP_RST_WORD;
                  evt = 1'b1;
               end else if (cnt_inc == st.duty_act) begin
                  next_st.ff = !st.ff;
               end
            end
            default: next_st.cnt = st.cnt;
         endcase
      end

      // register writes land in the data phase, byte in the low lane
      if (st.bus == CTP_BUS_WRITE && st.mapped) begin
         case (st.addr)
            `CTP_IDX_LOWER_CTL: next_st.lctl = hwdata[7:0];
            `CTP_IDX_UPPER_CTL: begin
               next_st.uctl = hwdata[7:0];
               // only a write made while stopped loads the flop, so stopping keeps the pin
               if (!run) begin
                  next_st.ff = hwdata[`CTP_UC_INIT_BIT];
               end
               if (!run && hwdata[`CTP_UC_RUN_BIT]) begin
                  next_st.cnt = `CTP_RST_WORD;
               end
            end
            `CTP_IDX_PER_LOW:   next_st.per[7:0]        = hwdata[7:0];
            `CTP_IDX_PER_HIGH:  next_st.per[15:8]       = hwdata[7:0];
            `CTP_IDX_DUTY_LOW:  next_st.duty_pend[7:0]  = hwdata[7:0];
            `CTP_IDX_DUTY_HIGH: next_st.duty_pend[15:8] = hwdata[7:0];
            `CTP_IDX_INT_EN:    next_st.ie              = hwdata[7:0];
            default:            next_st.ie              = st.ie;
         endcase
      end

      // duty shadow: held while pwm runs, moved at the period event;
      // a write in the event cycle is not taken, the older pending value moves
      if (mode == `CTP_MODE_PWM16 && run) begin
         if (evt) begin
            next_st.duty_act = st.duty_pend;
         end
      end else begin
         next_st.duty_act = next_st.duty_pend;
      end

      next_st.irq = evt && st.ie[`CTP_IE_PERIOD_BIT] && st.ie[`CTP_IE_MASTER_BIT];
      next_st.pwm_pin = !next_st.ff;
      next_st.ppg_pin = !next_st.ff;
   end

   // state register; every field takes a constant at reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '{bus: CTP_BUS_IDLE, addr: 3'h0, mapped: 1'b0, hrdata: 32'h00000000,
                 hreadyout: 1'b1, hresp: 1'b0, lctl: `CTP_RST_BYTE, uctl: `CTP_RST_BYTE,
                 per: `CTP_RST_WORD, duty_pend: `CTP_RST_WORD, duty_act: `CTP_RST_WORD,
                 ie: `CTP_RST_BYTE, cnt: `CTP_RST_WORD, ff: 1'b0, pwm_pin: 1'b1,
                 ppg_pin: 1'b1, irq: 1'b0, hist: 2'b00, ext_lvl: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // outputs come straight from state flops
   assign hreadyout            = st.hreadyout;
   assign hrdata               = st.hrdata;
   assign hresp                = st.hresp;
   assign pwm_output_pin       = st.pwm_pin;
   assign pulse_gen_output_pin = st.ppg_pin;
   assign period_interrupt     = st.irq;

   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_pwm_pin_inverse: assert property (pwm_output_pin == !st.ff && pulse_gen_output_pin == !st.ff)
      else $error("output pin is not the inverse of the flop");
   a_timer_match: assert property (step && mode == `CTP_MODE_TIMER16 && cnt_inc == st.per && !ctl_wr
                                   |=> st.cnt == 16'h0000)
      else $error("timer match did not clear the counter");
   a_pwm_overflow: assert property (step && mode == `CTP_MODE_PWM16 && st.cnt == 16'hFFFF && !ctl_wr
                                    |=> st.cnt == 16'h0000 && st.ff != $past(st.ff))
      else $error("pwm overflow did not toggle and clear");
   a_stop_holds: assert property (!run && !ctl_wr |=> $stable(st.ff) && $stable(st.cnt))
      else $error("stopped timer changed flop or counter");
   a_restart_zero: assert property (ctl_wr && !run && hwdata[3] |=> st.cnt == 16'h0000 && run)
      else $error("start did not clear the counter");
   a_shadow_hold: assert property (mode == `CTP_MODE_PWM16 && run && !evt && !ctl_wr
                                   |=> $stable(st.duty_act))
      else $error("active duty changed between period events");
   a_irq_gate: assert property (period_interrupt |-> $past(st.ie[4] && st.ie[0]))
      else $error("interrupt raised while not enabled");
   a_timer_sources: assert property (run && mode == `CTP_MODE_TIMER16 && !ctl_wr
                                     && st.lctl[6:4] inside {3'h4, 3'h5, 3'h6}
                                     |=> $stable(st.cnt))
      else $error("timer mode counted on a pwm-only source");
   a_ext_filter: assert property (step && st.lctl[6:4] == 3'h7 |-> $past(count_input_pin, 1) == 1'b0
                                  && $past(count_input_pin, 2) == 1'b0)
      else $error("external count taken without a two-cycle low level");
   a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite
                                 |=> !hreadyout ##1 hreadyout)
      else $error("read wait state is wrong");
endmodule
`default_nettype wire

// *** verif/ctp_timer_tb.sv ***
// self-checking testbench of the cascaded timer, ahb-lite driven, with an integer model of the pins
`include "ctp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ctp_timer_tb;
   // bus and control drives, all given a value at time zero
   logic        hclk    = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel    = 1'b0;
   logic        hwrite  = 1'b0;
   logic [1:0]  htrans  = 2'h0;
   logic [31:0] haddr   = 32'h0;
   logic [31:0] hwdata  = 32'h0;
   logic [7:0]  tk      = 8'hFF;
   logic        dvk     = 1'b0;
   logic        slow    = 1'b0;
   logic        ext     = 1'b0;
   logic        ext_man = 1'b0;
   logic        ext_val = 1'b0;
   // design outputs
   wire logic        hreadyout;
   wire logic        hresp;
   wire logic [31:0] hrdata;
   wire logic        pwm_pin;
   wire logic        ppg_pin;
   wire logic        irq;
   // model values and bookkeeping
   int          miscompares = 0;
   int          tests_run   = 0;
   int          n, per, dty, d2;
   int          c_pwm = 0, c_ppg = 0, lw_pwm = 0, lw_ppg = 0;
   logic [31:0] r, r2;

   ctp_timer dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .source_ticks(tk),
      .divider_clock_option(dvk), .slow_run_modes(slow), .count_input_pin(ext),
      .pwm_output_pin(pwm_pin), .pulse_gen_output_pin(ppg_pin), .period_interrupt(irq));

   // 250 mhz clock
   always #2 hclk = ~hclk;

   // the external count input only matters in code 7, so noise on it must not disturb other sources
   // the external scenario takes the pin over with a fixed pattern
   always @(posedge hclk) begin
      ext <= ext_man ? ext_val : 1'($urandom);
   end

   // low-width monitors: length of the last completed low phase of each pin
   always @(posedge hclk) begin
      if (pwm_pin === 1'b0) c_pwm <= c_pwm + 1;
      else begin
         if (c_pwm != 0) lw_pwm <= c_pwm;
         c_pwm <= 0;
      end
      if (ppg_pin === 1'b0) c_ppg <= c_ppg + 1;
      else begin
         if (c_ppg != 0) lw_ppg <= c_ppg;
         c_ppg <= 0;
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // one single transfer; entered just after a rising edge, returns just after the data-phase edge
   task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      chk(hresp, 32'h0, "okay response");
   endtask

   task automatic wr(input logic [2:0] idx, input logic [7:0] d);
      bus(1'b1, {27'h0, idx, 2'b00}, d, r2);
   endtask

   task automatic rd(input logic [2:0] idx);
      bus(1'b0, {27'h0, idx, 2'b00}, 8'h00, r);
   endtask

   // counts cycles up to the next interrupt pulse, giving up at the limit
   task automatic wait_irq(input int limit);
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (irq !== 1'b1 && n < limit);
   endtask

   // watchdog: the pwm period alone is 65536 cycles
   initial begin
      repeat (90000) @(posedge hclk);
      miscompares++;
      $display("BAD t=%0t watchdog expired", $time);
      results();
   end

   initial begin
      void'($urandom(32'h40CD2807));
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(pwm_pin, 1'b1, "pwm pin after reset");
      chk(ppg_pin, 1'b1, "ppg pin after reset");
      chk(irq, 1'b0, "irq after reset");
      for (int i = 0; i < 8; i++) begin
         rd(i[2:0]);
         chk(r, 32'h0, "register reset value");
      end
      bus(1'b0, 32'h20, 8'h00, r);
      chk(r, 32'h0, "unmapped read");
      // timer mode: period above 255 so the low byte must carry
      per = 256 + $urandom_range(4, 40);
      wr(`CTP_IDX_LOWER_CTL, 8'h33);
      wr(`CTP_IDX_INT_EN, 8'h11);
      wr(`CTP_IDX_PER_HIGH, 8'(per >> 8));
      wr(`CTP_IDX_PER_LOW, 8'(per));
      wr(`CTP_IDX_UPPER_CTL, 8'h04);
      wr(`CTP_IDX_UPPER_CTL, 8'h0C);
      wait_irq(2000);
      wait_irq(2000);
      chk(n, per, "timer interrupt spacing");
      chk(n, per, "cascaded compare");
      // either enable alone keeps the interrupt quiet
      wr(`CTP_IDX_INT_EN, 8'h10);
      wait_irq(per + 8);
      chk(n, per + 8, "master enable off");
      wr(`CTP_IDX_INT_EN, 8'h01);
      wait_irq(per + 8);
      chk(n, per + 8, "period enable off");
      wr(`CTP_IDX_INT_EN, 8'h11);
      // stop holds the count, restart begins at zero
      wr(`CTP_IDX_UPPER_CTL, 8'h04);
      rd(`CTP_IDX_COUNT);
      r2 = r;
      repeat (5) @(posedge hclk);
      rd(`CTP_IDX_COUNT);
      chk(r, r2, "stopped counter holds");
      wr(`CTP_IDX_UPPER_CTL, 8'h0C);
      rd(`CTP_IDX_COUNT);
      chk(r < 32'h8, 1'b1, "restart from zero");
      // slow mode: high-frequency source code 3 must not count
      slow <= 1'b1;
      rd(`CTP_IDX_COUNT);
      r2 = r;
      repeat (6) @(posedge hclk);
      rd(`CTP_IDX_COUNT);
      chk(r, r2, "hf source idle in slow mode");
      slow <= 1'b0;
      // external source: five clean pulses with period 3 leave count 2, a one-cycle glitch is ignored
      ext_man <= 1'b1;
      ext_val <= 1'b0;
      wr(`CTP_IDX_UPPER_CTL, 8'h04);
      wr(`CTP_IDX_LOWER_CTL, 8'h73);
      wr(`CTP_IDX_PER_HIGH, 8'h00);
      wr(`CTP_IDX_PER_LOW, 8'h03);
      wr(`CTP_IDX_UPPER_CTL, 8'h0C);
      for (int i = 0; i < 5; i++) begin
         ext_val <= 1'b1;
         repeat (3) @(posedge hclk);
         ext_val <= 1'b0;
         repeat (3) @(posedge hclk);
      end
      ext_val <= 1'b1;
      @(posedge hclk);
      ext_val <= 1'b0;
      repeat (6) @(posedge hclk);
      rd(`CTP_IDX_COUNT);
      chk(r, 32'h2, "external pulses counted");
      ext_man <= 1'b0;
      wr(`CTP_IDX_LOWER_CTL, 8'h33);
      // pulse generator: first write stops, second loads the flop while stopped
      dty = $urandom_range(20, 60);
      per = dty + $urandom_range(10, 60);
      wr(`CTP_IDX_UPPER_CTL, 8'h07);
      wr(`CTP_IDX_UPPER_CTL, 8'h07);
      wr(`CTP_IDX_PER_LOW, 8'(per));
      wr(`CTP_IDX_PER_HIGH, 8'(per >> 8));
      wr(`CTP_IDX_DUTY_LOW, 8'(dty));
      wr(`CTP_IDX_DUTY_HIGH, 8'(dty >> 8));
      wr(`CTP_IDX_UPPER_CTL, 8'h0F);
      wait_irq(500);
      wait_irq(500);
      chk(n, per, "ppg period");
      repeat (3) @(posedge hclk);
      chk(lw_ppg, per - dty, "ppg low width");
      chk(pwm_pin, ppg_pin, "both pins show inverse flop");
      // stopping while low holds the pin; the next stopped write sets it
      do @(posedge hclk); while (ppg_pin !== 1'b0);
      wr(`CTP_IDX_UPPER_CTL, 8'h07);
      repeat (per) @(posedge hclk);
      chk(ppg_pin, 1'b0, "pin held after stop");
      wr(`CTP_IDX_UPPER_CTL, 8'h87);
      repeat (3) @(posedge hclk);
      chk(ppg_pin, 1'b0, "initial level one");
      wr(`CTP_IDX_UPPER_CTL, 8'h07);
      repeat (3) @(posedge hclk);
      chk(ppg_pin, 1'b1, "initial level zero");
      // pwm: long period, short low phase; the new duty waits for the overflow
      dty = 16'hFF00 + $urandom_range(20, 200);
      d2  = dty - 16'h10;
      wr(`CTP_IDX_UPPER_CTL, 8'h06);
      wr(`CTP_IDX_DUTY_LOW, 8'(dty));
      wr(`CTP_IDX_DUTY_HIGH, 8'(dty >> 8));
      rd(`CTP_IDX_DUTY_LOW);
      chk(r, {24'h0, 8'(dty)}, "duty taken at once when stopped");
      wr(`CTP_IDX_UPPER_CTL, 8'h0E);
      do @(posedge hclk); while (pwm_pin !== 1'b0);
      wr(`CTP_IDX_DUTY_LOW, 8'(d2));
      wr(`CTP_IDX_DUTY_HIGH, 8'(d2 >> 8));
      rd(`CTP_IDX_DUTY_LOW);
      chk(r, {24'h0, 8'(dty)}, "running duty read shows active");
      wait_irq(400);
      chk(n < 400, 1'b1, "pwm overflow event");
      repeat (3) @(posedge hclk);
      chk(lw_pwm, 65536 - dty, "pwm low width");
      chk(pwm_pin, 1'b1, "pwm pin after overflow");
      rd(`CTP_IDX_DUTY_LOW);
      chk(r, {24'h0, 8'(d2)}, "shadow duty moved at event");
      results();
   end
endmodule
`default_nettype wire
